// File: hw/pspio_port.sv
// shared pwm / general purpose port with register file and pad control
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
//
// Summary of operation
// - data read: latch if direction bit 1, else pin
// - enabled pwm channel owns its pin, except pin 7 while shutdown is enabled
// - shutdown makes pin 7 a pwm input
// - pin input register always shows pins
// - pin input register ignores writes
// - direction bit 1 output, 0 input
// - direction ignored at pads while channel enabled, still used by data read
// - reads lag direction change three cycles: one output register, two sync stages
// - reduced drive bit only on outputs
// - pull enable only on inputs, off at reset
// - polarity 1 pull-down, 0 pull-up
// - latch writes stored, drive only gpio outputs
// - config registers writable at any time
// - reset leaves pins hi-z inputs, no pull
// - clocks stop externally in stop mode
// - all registers reset asynchronously
// - output latch clears to zero on reset
module pspio_port
  import pspio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [PSPIO_W-1:0] pwm_chan_en,
  input wire logic [PSPIO_W-1:0] pwm_out,
  input wire logic pwm_shutdown_en,
  output logic pwm_shutdown_in,
  input wire logic [PSPIO_W-1:0] shared_port_pins_in,
  output logic [PSPIO_W-1:0] shared_port_pins_out,
  output logic [PSPIO_W-1:0] shared_port_pins_oe_n,
  output logic [PSPIO_W-1:0] pad_reduced_drive,
  output logic [PSPIO_W-1:0] pad_pull_up,
  output logic [PSPIO_W-1:0] pad_pull_down
);
  //////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] port_output_latch_r;
  logic [7:0] port_direction_r;
  logic [7:0] port_drive_strength_r;
  logic [7:0] port_pull_enable_r;
  logic [7:0] port_pull_polarity_r;
  logic [7:0] pin_sync;
  logic [7:0] rdata_nxt;

  wire sel_latch = bus_addr == PSPIO_ADDR_LATCH;
  wire sel_pin_in = bus_addr == PSPIO_ADDR_PIN_IN;
  wire sel_dir = bus_addr == PSPIO_ADDR_DIR;
  wire sel_drive = bus_addr == PSPIO_ADDR_DRIVE;
  wire sel_pull_en = bus_addr == PSPIO_ADDR_PULL_EN;
  wire sel_pull_pol = bus_addr == PSPIO_ADDR_PULL_POL;

  // pin input register has no write path at all
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port_output_latch_r <= PSPIO_RST_ZERO;
      port_direction_r <= PSPIO_RST_ZERO;
      port_drive_strength_r <= PSPIO_RST_ZERO;
      port_pull_enable_r <= PSPIO_RST_ZERO;
      port_pull_polarity_r <= PSPIO_RST_ZERO;
    end
    else if (bus_wr)
    begin
      if (sel_latch)
        port_output_latch_r <= bus_wdata;
      if (sel_dir)
        port_direction_r <= bus_wdata;
      if (sel_drive)
        port_drive_strength_r <= bus_wdata;
      if (sel_pull_en)
        port_pull_enable_r <= bus_wdata;
      if (sel_pull_pol)
        port_pull_polarity_r <= bus_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin sampling
  pspio_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(shared_port_pins_in),
    .sync_out(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////
  // pin ownership and direction
  logic [7:0] shut_mask;
  logic [7:0] pwm_drive;
  logic [7:0] is_out;
  logic [7:0] gpio_out;
  logic [7:0] pin_val_nxt;

  assign shut_mask = pwm_shutdown_en ? (8'h01 << PSPIO_SHUTDOWN_BIT) : 8'h00;
  assign pwm_drive = pwm_chan_en & ~shut_mask;
  // enabled channel overrides direction bit
  assign is_out = (pwm_drive | (port_direction_r & ~pwm_chan_en)) & ~shut_mask;
  assign gpio_out = is_out & ~pwm_chan_en;
  assign pin_val_nxt = (pwm_drive & pwm_out) | (gpio_out & port_output_latch_r);

  // data read: latch for direction 1, synced pin otherwise
  assign rdata_nxt = sel_latch ?
    ((port_direction_r & port_output_latch_r) | (~port_direction_r & pin_sync)) :
    sel_pin_in ? pin_sync :
    sel_dir ? port_direction_r :
    sel_drive ? port_drive_strength_r :
    sel_pull_en ? port_pull_enable_r :
    sel_pull_pol ? port_pull_polarity_r : PSPIO_RST_ZERO;

  //////////////////////////////////////////////////////////////////////
  // registered outputs; stop mode gates ref_clk upstream, all state holds
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_rdata <= PSPIO_RST_ZERO;
      shared_port_pins_out <= PSPIO_RST_ZERO;
      shared_port_pins_oe_n <= ~PSPIO_RST_ZERO;
      pad_reduced_drive <= PSPIO_RST_ZERO;
      pad_pull_up <= PSPIO_RST_ZERO;
      pad_pull_down <= PSPIO_RST_ZERO;
      pwm_shutdown_in <= 1'b0;
    end
    else
    begin
      bus_rdata <= bus_rd ? rdata_nxt : PSPIO_RST_ZERO;
      shared_port_pins_out <= pin_val_nxt;
      shared_port_pins_oe_n <= ~is_out;
      pad_reduced_drive <= port_drive_strength_r & is_out;
      pad_pull_up <= port_pull_enable_r & ~port_pull_polarity_r & ~is_out;
      pad_pull_down <= port_pull_enable_r & port_pull_polarity_r & ~is_out;
      pwm_shutdown_in <= pin_sync[PSPIO_SHUTDOWN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  data_read_mux_a: assert property (bus_rd && sel_latch |=>
    bus_rdata == (($past(port_direction_r) & $past(port_output_latch_r))
      | (~$past(port_direction_r) & $past(pin_sync))))
    else $error("data read mux wrong");
  pwm_owns_pin_a: assert property (pwm_chan_en[0] |=> !shared_port_pins_oe_n[0]
    && shared_port_pins_out[0] == $past(pwm_out[0]))
    else $error("pwm channel 0 not driving");
  shutdown_input_a: assert property (pwm_shutdown_en |=> shared_port_pins_oe_n[7])
    else $error("pin 7 not input in shutdown");
  pin_input_read_a: assert property (bus_rd && sel_pin_in |=> bus_rdata == $past(pin_sync))
    else $error("pin input read wrong");
  pin_input_ro_a: assert property (bus_wr && sel_pin_in |=> $stable(port_output_latch_r)
    && $stable(port_direction_r) && $stable(port_pull_enable_r))
    else $error("pin input write changed state");
  direction_ctl_a: assert property (!pwm_chan_en[1] && !pwm_shutdown_en |=>
    shared_port_pins_oe_n[1] == !$past(port_direction_r[1]))
    else $error("direction bit ignored");
  sync_delay_a: assert property ($stable(shared_port_pins_in)[*3] ##0 (bus_rd && sel_pin_in)
    |=> bus_rdata == $past(shared_port_pins_in))
    else $error("pin sample latency wrong");
  drive_input_a: assert property (shared_port_pins_oe_n[2] |-> !pad_reduced_drive[2])
    else $error("reduced drive on input");
  pull_output_a: assert property (!shared_port_pins_oe_n[3] |->
    !pad_pull_up[3] && !pad_pull_down[3])
    else $error("pull device on output");
  pull_polarity_a: assert property (pad_pull_down[4] |-> !pad_pull_up[4])
    else $error("both pulls active");
  latch_write_a: assert property (bus_wr && sel_latch |=> port_output_latch_r == $past(bus_wdata))
    else $error("latch write lost");

  cover_pwm_c: cover property (pwm_chan_en[0] ##1 pwm_chan_en[0] == 1'b0);
  cover_shutdown_c: cover property (pwm_shutdown_en && pwm_chan_en[7]);
  cover_read_c: cover property (bus_rd && sel_latch && port_direction_r != 8'h00);
endmodule

// File: hw/pspio_pkg.sv
// constants for the shared pwm port block
package pspio_pkg;
  localparam int PSPIO_W = 8;
  localparam logic [15:0] PSPIO_ADDR_LATCH = 16'h00f0;
  localparam logic [15:0] PSPIO_ADDR_PIN_IN = 16'h00f1;
  localparam logic [15:0] PSPIO_ADDR_DIR = 16'h00f2;
  localparam logic [15:0] PSPIO_ADDR_DRIVE = 16'h00f3;
  localparam logic [15:0] PSPIO_ADDR_PULL_EN = 16'h00f4;
  localparam logic [15:0] PSPIO_ADDR_PULL_POL = 16'h00f5;
  localparam logic [7:0] PSPIO_RST_ZERO = 8'h00;
  localparam int PSPIO_SHUTDOWN_BIT = 7;
  localparam int PSPIO_SYNC_STAGES = 2;
endpackage

// File: hw/pspio_sync.sv
// two-stage pin synchroniser, one stage pair per pin
`timescale 1ns/1ps
module pspio_sync
  import pspio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [PSPIO_W-1:0] async_in,
  output logic [PSPIO_W-1:0] sync_out
);
  logic [PSPIO_W-1:0] meta_r;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= PSPIO_RST_ZERO;
      sync_out <= PSPIO_RST_ZERO;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// File: bench/pspio_board.sv
// board side of the pins: pulls and an external source on each wire
`timescale 1ns/1ps
module pspio_board
  import pspio_pkg::*;
(
  input wire logic [PSPIO_W-1:0] drive,
  input wire logic [PSPIO_W-1:0] oe_n,
  input wire logic [PSPIO_W-1:0] pull_up,
  input wire logic [PSPIO_W-1:0] pull_down,
  input wire logic [PSPIO_W-1:0] ext_src,
  output logic [PSPIO_W-1:0] pins
);
  // released wire follows its pull, else the external source
  assign pins = (~oe_n & drive) | (oe_n & ~pull_down & (pull_up | ext_src));
endmodule

// File: bench/pwm_shared_port_io_tb_top.sv
// self-checking bench for the shared pwm port
`timescale 1ns/1ps
module pwm_shared_port_io_tb_top
  import pspio_pkg::*;
();
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_wr = 1'b0, bus_rd = 1'b0, sd = 1'b0, shut_in;
  logic [7:0] bus_wdata = 8'h00, en = 8'h00, pwm = 8'h00, ext = 8'h00;
  logic [7:0] dir = 8'h00, lat = 8'h00, drv = 8'h00, pe = 8'h00, pol = 8'h00;
  logic [7:0] bus_rdata, pins, p_out, oe_n, rdrv, pu, pd, got, eo, pin_e;
  int n_mismatch = 0, num_checks = 0, cyc = 0, seed = 32'hf266;
  always #20 ref_clk = ~ref_clk;
  pspio_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pwm_chan_en(en), .pwm_out(pwm), .pwm_shutdown_en(sd), .pwm_shutdown_in(shut_in),
    .shared_port_pins_in(pins), .shared_port_pins_out(p_out),
    .shared_port_pins_oe_n(oe_n), .pad_reduced_drive(rdrv), .pad_pull_up(pu),
    .pad_pull_down(pd));
  pspio_board board (.drive(p_out), .oe_n(oe_n), .pull_up(pu), .pull_down(pd),
    .ext_src(ext), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  // settle pads and synchroniser, then check every output and read-back
  task automatic check_all();
    eo = (en | dir) & ~{sd, 7'h00};
    pin_e = (eo & ((en & pwm) | (~en & lat))) | (~eo & ~(pe & pol) & ((pe & ~pol) | ext));
    repeat (4) @(posedge ref_clk);
    #1;
    chk("oe_n", ~eo, oe_n);
    chk("pin_out", eo & ((en & pwm) | (~en & lat)), eo & p_out);
    chk("drive", drv & eo, rdrv);
    chk("pull_up", pe & ~pol & ~eo, pu);
    chk("pull_down", pe & pol & ~eo, pd);
    chk("shut_in", {7'h00, pin_e[7]}, {7'h00, shut_in});
    rd(PSPIO_ADDR_PIN_IN, got);
    chk("pin_in", pin_e, got);
    rd(PSPIO_ADDR_LATCH, got);
    chk("latch", (dir & lat) | (~dir & pin_e), got);
    rd(PSPIO_ADDR_DIR, got);
    chk("dir", dir, got);
    rd(PSPIO_ADDR_DRIVE, got);
    chk("drv", drv, got);
    rd(PSPIO_ADDR_PULL_EN, got);
    chk("pe", pe, got);
    rd(PSPIO_ADDR_PULL_POL, got);
    chk("pol", pol, got);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    chk("rst_oe_n", 8'hff, oe_n);
    chk("rst_pull", 8'h00, pu | pd);
    sys_rst <= 1'b0;
    dir = 8'hff;
    wr(PSPIO_ADDR_DIR, dir);
    check_all();
    wr(PSPIO_ADDR_PIN_IN, 8'h5a);
    check_all();
    rd(16'h00f7, got);
    chk("unmapped", 8'h00, got);
    for (int i = 0; i < 18; i++)
    begin
      @(posedge ref_clk);
      en <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
      sd <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : rnd() > 8'h7f;
      pwm <= rnd();
      ext <= rnd();
      {dir, lat, drv, pe, pol} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      wr(PSPIO_ADDR_LATCH, lat);
      wr(PSPIO_ADDR_DIR, dir);
      wr(PSPIO_ADDR_DRIVE, drv);
      wr(PSPIO_ADDR_PULL_EN, pe);
      wr(PSPIO_ADDR_PULL_POL, pol);
      check_all();
    end
    close_out();
  end
endmodule
